// ### pkg/cmpc_pkg.sv
// constants and types for the comparator control logic
`default_nettype none
package cmpc_pkg;
    localparam logic [7:0] ADDR_MODE    = 8'h9d;
    localparam logic [7:0] ADDR_MUX     = 8'h9f;
    localparam logic [7:0] ADDR_CTRL    = 8'h9b;
    localparam logic [7:0] ADDR_ISTAT   = 8'h9a;
    localparam logic [7:0] ADDR_IMASK   = 8'h99;
    localparam logic [1:0] MODE_RESET   = 2'h2;
    localparam logic [7:0] MUX_RESET    = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam int         CTRL_EN_BIT  = 7;
    localparam int         CTRL_OUT_BIT = 6;
    localparam int         HYP_LSB      = 2;
    localparam int         HYN_LSB      = 0;
    localparam int         MUXN_LSB     = 4;
    localparam int         MUXP_LSB     = 0;
    localparam int         IRQ_RISE_BIT = 0;
    localparam int         IRQ_FALL_BIT = 1;
    localparam int         SYNC_STAGES  = 2;
    typedef enum logic [1:0] {
        CMPC_HYS_OFF,
        CMPC_HYS_5MV,
        CMPC_HYS_10MV,
        CMPC_HYS_20MV
    } cmpc_hys_t;
endpackage
`default_nettype wire

// ### pkg/cmpc_sync_if.sv
// comparator result crossing into the system clock domain
`timescale 1ns/1ns
`default_nettype none
interface cmpc_sync_if;
    logic raw;
    logic synced;
    logic rise;
    logic fall;
    modport core (output raw, input synced, input rise, input fall);
    modport sync (input raw, output synced, output rise, output fall);
endinterface
`default_nettype wire

// ### src/cmpc_sync.sv
// two-stage synchroniser with edge detection on the settled level
`timescale 1ns/1ns
`default_nettype none
module cmpc_sync (
    input  wire logic mclk,
    input  wire logic resetn,
    cmpc_sync_if.sync s
);
    logic meta_r;
    logic stab_r;
    logic prev_r;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            stab_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= s.raw;
            stab_r <= meta_r;
            prev_r <= stab_r;
        end
    end
    assign s.synced = stab_r;
    assign s.rise   = stab_r & ~prev_r;
    assign s.fall   = ~stab_r & prev_r;
endmodule
`default_nettype wire

// ### src/cmpc_sticky.sv
// sticky event flag, set wins over a write-one clear
`timescale 1ns/1ns
`default_nettype none
module cmpc_sticky (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### src/cmpc_top.sv
// comparator control: registers, input mux, hysteresis codes, output routing, interrupt
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - the comparator result is offered as a pollable status bit, an interrupt source and a port pin signal.
// - the pin signal is selectable as the raw asynchronous result or a clock-synchronised copy, the raw path being pure logic.
// - while the comparator is disabled the pin signal is forced low.
// - bits 1-0 of the mode register pick one of four response settings, reset to code 2, upper bits read zero.
// - the low four bits of the control register hold separate negative and positive hysteresis fields.
// - the negative hysteresis field chooses off, 5, 10 or 20 mV and goes to the analog block as a code.
// - the positive hysteresis field offers the same choices independently.
// - mux bits 5-4 pick port bit 1,3,5 or 7 as negative input and bits 1-0 pick 0,2,4 or 6 as positive input.
module cmpc_top (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       cmp_result,
    output logic            cmp_enable,
    output logic      [1:0] response_mode,
    output logic      [1:0] hys_neg_code,
    output logic      [1:0] hys_pos_code,
    output logic      [2:0] neg_input_pin,
    output logic      [2:0] pos_input_pin,
    output logic            pin_out,
    output logic            irq
);
    logic [1:0] mode_r;
    logic [7:0] mux_r;
    logic [7:0] ctrl_r;
    logic [1:0] mask_r;
    logic [7:0] rdata_r;
    logic [1:0] stat;

    cmpc_sync_if sif ();

    wire wr_mode  = reg_wr && (reg_addr == cmpc_pkg::ADDR_MODE);
    wire wr_mux   = reg_wr && (reg_addr == cmpc_pkg::ADDR_MUX);
    wire wr_ctrl  = reg_wr && (reg_addr == cmpc_pkg::ADDR_CTRL);
    wire wr_stat  = reg_wr && (reg_addr == cmpc_pkg::ADDR_ISTAT);
    wire wr_mask  = reg_wr && (reg_addr == cmpc_pkg::ADDR_IMASK);
    wire en       = ctrl_r[cmpc_pkg::CTRL_EN_BIT];
    wire sync_sel = ctrl_r[cmpc_pkg::CTRL_OUT_BIT];

    // gating the raw input while disabled keeps stale edges out of the flags
    assign sif.raw = cmp_result & en;

    cmpc_sync u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .s      (sif)
    );

    cmpc_sticky u_rise (
        .mclk   (mclk),
        .resetn (resetn),
        .set    (sif.rise),
        .clr    (wr_stat && reg_wdata[cmpc_pkg::IRQ_RISE_BIT]),
        .flag   (stat[cmpc_pkg::IRQ_RISE_BIT])
    );

    cmpc_sticky u_fall (
        .mclk   (mclk),
        .resetn (resetn),
        .set    (sif.fall),
        .clr    (wr_stat && reg_wdata[cmpc_pkg::IRQ_FALL_BIT]),
        .flag   (stat[cmpc_pkg::IRQ_FALL_BIT])
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode_r <= cmpc_pkg::MODE_RESET;
            mux_r  <= cmpc_pkg::MUX_RESET;
            ctrl_r <= cmpc_pkg::CTRL_RESET;
            mask_r <= 2'h0;
        end else begin
            if (wr_mode) mode_r <= reg_wdata[1:0];
            if (wr_mux)  mux_r  <= reg_wdata & 8'h33;
            if (wr_ctrl) ctrl_r <= reg_wdata & 8'hcf;
            if (wr_mask) mask_r <= reg_wdata[1:0];
        end
    end

    // control register: enable, output select, live result (read-only), hysteresis
    wire [7:0] ctrl_view = {ctrl_r[7:6], sif.synced, 1'b0, ctrl_r[3:0]};

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            cmpc_pkg::ADDR_MODE:  rd_mux = {6'h00, mode_r};
            cmpc_pkg::ADDR_MUX:   rd_mux = mux_r;
            cmpc_pkg::ADDR_CTRL:  rd_mux = ctrl_view;
            cmpc_pkg::ADDR_ISTAT: rd_mux = {6'h00, stat};
            cmpc_pkg::ADDR_IMASK: rd_mux = {6'h00, mask_r};
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_r;

    assign cmp_enable    = en;
    assign response_mode = mode_r;
    assign hys_neg_code  = ctrl_r[cmpc_pkg::HYN_LSB +: 2];
    assign hys_pos_code  = ctrl_r[cmpc_pkg::HYP_LSB +: 2];
    // port bit number: negative picks odd pins, positive even pins
    assign neg_input_pin = {mux_r[cmpc_pkg::MUXN_LSB +: 2], 1'b1};
    assign pos_input_pin = {mux_r[cmpc_pkg::MUXP_LSB +: 2], 1'b0};
    // raw path has no flop so it keeps working with the clock stopped
    assign pin_out = en & (sync_sel ? sif.synced : cmp_result);
    assign irq     = |(stat & mask_r);
endmodule
`default_nettype wire

// ### verification/cmpc_top_properties.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module cmpc_top_checker (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       cmp_result,
    input wire logic       cmp_enable,
    input wire logic [1:0] response_mode,
    input wire logic [1:0] hys_neg_code,
    input wire logic [1:0] hys_pos_code,
    input wire logic [2:0] neg_input_pin,
    input wire logic [2:0] pos_input_pin,
    input wire logic       pin_out,
    input wire logic       irq
);
    // shadow copies of sync select and mask, tracked from the bus
    logic       sel_r;
    logic [1:0] msk_r;
    always_ff @(posedge mclk) begin
        if (!resetn) {sel_r, msk_r} <= 3'h0;
        else if (reg_wr && reg_addr == 8'h9b) sel_r <= reg_wdata[6];
        else if (reg_wr && reg_addr == 8'h99) msk_r <= reg_wdata[1:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    pin_low_a: assert property (!cmp_enable |-> !pin_out) else $error("pin high while off");
    async_pin_a: assert property (cmp_enable && !sel_r |-> pin_out == cmp_result) else $error("raw pin");
    sync_pin_a: assert property (cmp_enable && sel_r && $past(cmp_enable, 2)
        |-> pin_out == $past(cmp_result, 2)) else $error("synced pin");
    mode_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h9d
        |-> reg_rdata == {6'h00, response_mode}) else $error("mode read");
    mux_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h9f
        |-> reg_rdata == {2'h0, neg_input_pin[2:1], 2'h0, pos_input_pin[2:1]}) else $error("mux read");
    mux_pin_a: assert property (reg_wr && reg_addr == 8'h9f
        |=> {neg_input_pin, pos_input_pin} == {$past(reg_wdata[5:4]), 1'b1, $past(reg_wdata[1:0]), 1'b0})
        else $error("mux pins");
    mode_wr_a: assert property (reg_wr && reg_addr == 8'h9d
        |=> {6'h00, response_mode} == ($past(reg_wdata) & 8'h03)) else $error("mode write");
    hys_wr_a: assert property (reg_wr && reg_addr == 8'h9b
        |=> {cmp_enable, 3'h0, hys_pos_code, hys_neg_code} == ($past(reg_wdata) & 8'h8f)) else $error("ctrl");
    irq_off_a: assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0 |-> !irq) else $error("masked irq");
    irq_rise_a: assert property (cmp_enable && $past(cmp_enable) && msk_r[0] && $rose(cmp_result)
        |-> ##[3:4] irq) else $error("no irq");
endmodule
bind cmpc_top cmpc_top_checker u_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_result(cmp_result), .cmp_enable(cmp_enable),
    .response_mode(response_mode), .hys_neg_code(hys_neg_code), .hys_pos_code(hys_pos_code),
    .neg_input_pin(neg_input_pin), .pos_input_pin(pos_input_pin), .pin_out(pin_out), .irq(irq));
`default_nettype wire

// ### verification/cmpc_top_tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module cmpc_top_tb;
    logic       mclk = 0, resetn = 0, wr_s = 0, rd_s = 0, res = 0, en, po, irq;
    logic [7:0] addr = 0, wd = 0, rdat, d;
    logic [1:0] rm, hn, hp;
    logic [2:0] ni, pi;
    int         error_cnt = 0, n_tests = 0, seed = 32'h28f9;
    always #5 mclk = ~mclk;
    cmpc_top DUT (.mclk(mclk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdat), .cmp_result(res), .cmp_enable(en), .response_mode(rm), .hys_neg_code(hn),
        .hys_pos_code(hp), .neg_input_pin(ni), .pos_input_pin(pi), .pin_out(po), .irq(irq));
    function automatic logic [7:0] mux_exp(input logic [7:0] v);
        return v & 8'h33;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk) {wr_s, addr, wd} <= {1'b1, a, v};
        @(posedge mclk) wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) {rd_s, addr} <= {1'b1, a};
        @(posedge mclk) rd_s <= 1'b0;
        #1 chk(rdat, e);
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rd(8'h9d, 8'h02);
        rd(8'h9f, 8'h00);
        for (int i = 0; i < 20; i++) begin
            // first passes walk every 2-bit code through each field
            d = (i < 4) ? {4{i[1:0]}} : 8'($random(seed));
            wr(8'h9d, d);
            rd(8'h9d, d & 8'h03);
            chk({6'h00, rm}, d & 8'h03);
            wr(8'h9f, d);
            rd(8'h9f, mux_exp(d));
            chk({2'h0, ni, pi}, {2'h0, d[5:4], 1'b1, d[1:0], 1'b0});
            wr(8'h9b, d & 8'h0f);
            // the write lands at this edge, so look once the flops have settled
            #1 chk({4'h0, hp, hn}, d & 8'h0f);
            chk({7'h0, en}, 8'h00);
            rd(8'h9c, 8'h00);
        end
        wr(8'h99, 8'h01);
        wr(8'h9b, 8'h80);
        @(posedge mclk) res <= 1'b1;
        #1 chk({7'h0, po}, 8'h01);
        chk({7'h0, en}, 8'h01);
        repeat (4) @(posedge mclk);
        #1 chk({7'h0, irq}, 8'h01);
        rd(8'h9a, 8'h01);
        wr(8'h9a, 8'h01);
        @(posedge mclk) #1 chk({7'h0, irq}, 8'h00);
        wr(8'h9b, 8'hc0);
        @(posedge mclk) res <= 1'b0;
        #1 chk({7'h0, po}, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, po}, 8'h00);
        rd(8'h9b, 8'hc0);
        wr(8'h9b, 8'h00);
        @(posedge mclk) res <= 1'b1;
        #1 chk({7'h0, po}, 8'h00);
        rd(8'h9a, 8'h02);
        wr(8'h99, 8'h02);
        @(posedge mclk) #1 chk({7'h0, irq}, 8'h01);
        end_sim();
    end
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
